// File: hw/fmac_pkg.sv
package fmac_pkg;

	// Register offsets
	localparam logic [7:0] FMAC_MASK_OFS   = 8'h14;
	localparam logic [7:0] FMAC_CTRL_OFS   = 8'h15;
	localparam logic [7:0] FMAC_CHAN_OFS   = 8'h16;
	localparam logic [7:0] FMAC_RES_HI_OFS = 8'h17;

	// Values after reset
	localparam logic [7:0]  FMAC_MASK_RST = 8'h00;
	localparam logic [7:0]  FMAC_CTRL_RST = 8'h30;
	localparam logic [7:0]  FMAC_CHAN_RST = 8'h00;
	localparam logic [15:0] FMAC_RES_RST  = 16'h0000;

	// Writable bits; reserved ones drop out
	localparam logic [7:0] FMAC_MASK_WMASK = 8'hF9;
	localparam logic [7:0] FMAC_CTRL_WMASK = 8'hF0;
	localparam logic [7:0] FMAC_CHAN_WMASK = 8'hFD;
	// Reserved channel bit reads as one
	localparam logic [7:0] FMAC_CHAN_RDONE = 8'h02;

	// Field positions
	localparam int FMAC_CTRL_EN_BIT   = 7;
	localparam int FMAC_CTRL_RATE_BIT = 6;
	localparam int FMAC_CTRL_SPD_LSB  = 4;
	localparam int FMAC_CHAN_IBUS_BIT = 7;

	// Serial bus bit count per byte
	localparam logic [3:0] FMAC_BYTE_BITS = 4'h8;

	typedef enum logic [1:0] {
		FMAC_RES_15 = 2'b00,
		FMAC_RES_14 = 2'b01,
		FMAC_RES_13 = 2'b10,
		FMAC_RES_12 = 2'b11
	} fmac_speed_type;

	// Fault inputs, laid out like the mask register
	typedef struct packed {
		logic input_overvoltage_fault;
		logic thermal_shutdown_fault;
		logic battery_overvoltage_fault;
		logic safety_timer_fault;
		logic system_short_fault;
		logic unused_2;
		logic unused_1;
		logic buck_fault_state;
	} fmac_fault_type;

	typedef struct packed {
		logic           enable;
		logic           one_shot;
		fmac_speed_type speed;
	} fmac_conv_cfg_type;

endpackage

// File: hw/fmac_regs.sv
module fmac_regs
	import fmac_pkg::*;
#(
	// Arbitrary serial bus address
	parameter logic [6:0] DEV_ADDR = 7'h2A
)(
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	input  wire logic               reg_reset,
	input  wire logic               wdt_expire,
	input  wire fmac_fault_type     faults,
	input  wire logic               conv_done,
	input  wire logic               conv_done_irq_mask,
	input  wire logic               result_valid,
	input  wire logic [15:0]        bus_current_result,
	output logic                    irq_pulse,
	output fmac_conv_cfg_type       conv_cfg,
	output logic [7:0]              channel_off,
	output logic [15:0]             bus_current_result_q
);
	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_ADDR     = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_PTR      = 4'h3,
		ST_PTR_ACK  = 4'h4,
		ST_WR       = 4'h5,
		ST_WR_ACK   = 4'h6,
		ST_RD       = 4'h7,
		ST_RD_ACK   = 4'h8
	} fmac_state_type;
	logic [2:0]     scl_sync_reg;
	logic [2:0]     sda_sync_reg;
	fmac_state_type state_reg;
	logic [3:0]     cnt_reg;
	logic [7:0]     shift_reg;
	logic           rw_reg;
	logic           nack_reg;
	logic [7:0]     ptr_reg;
	logic [7:0]     mask_reg;
	logic [7:0]     ctrl_reg;
	logic [7:0]     chan_reg;
	logic [7:0]     fault_s1_reg;
	logic [7:0]     fault_s2_reg;
	logic [7:0]     fault_d_reg;
	logic           done_d_reg;
	logic [7:0]     fault_rise;
	logic           done_event;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_det;
	logic           stop_det;
	logic           byte_end;
	logic           wr_strobe;
	logic           rd_byte_end;
	logic [7:0]     rd_val;
	////////////////////////////////////////////////////////////////////
	// Serial bus pins, two flops before any logic looks at them
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
		end
	end
	assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
	assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
	assign start_det = scl_sync_reg[1] & scl_sync_reg[2] &
		~sda_sync_reg[1] & sda_sync_reg[2];
	assign stop_det  = scl_sync_reg[1] & scl_sync_reg[2] &
		sda_sync_reg[1] & ~sda_sync_reg[2];
	assign byte_end  = scl_fall && (cnt_reg == FMAC_BYTE_BITS);
	assign wr_strobe = (state_reg == ST_WR) && byte_end && !start_det &&
		!stop_det;
	assign rd_byte_end = (state_reg == ST_RD) && byte_end && !start_det &&
		!stop_det;
	always_comb begin
		case (ptr_reg)
			FMAC_MASK_OFS:   rd_val = mask_reg & FMAC_MASK_WMASK;
			FMAC_CTRL_OFS:   rd_val = ctrl_reg & FMAC_CTRL_WMASK;
			FMAC_CHAN_OFS:   rd_val = chan_reg | FMAC_CHAN_RDONE;
			FMAC_RES_HI_OFS: rd_val = bus_current_result_q[15:8];
			default:         rd_val = 8'h00;
		endcase
	end
	////////////////////////////////////////////////////////////////////
	// Byte engine; open drain, so only a low level is ever driven
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg    <= 1'b0;
			nack_reg  <= 1'b0;
			sda_oe    <= 1'b0;
			sda_out   <= 1'b0;
		end else if (start_det) begin
			state_reg <= ST_ADDR;
			cnt_reg   <= 4'h0;
			sda_oe    <= 1'b0;
		end else if (stop_det) begin
			state_reg <= ST_IDLE;
			sda_oe    <= 1'b0;
		end else begin
			case (state_reg)
				ST_ADDR, ST_PTR, ST_WR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
						cnt_reg   <= cnt_reg + 4'h1;
					end else if (byte_end) begin
						cnt_reg <= 4'h0;
						if (state_reg != ST_ADDR) begin
							sda_oe    <= 1'b1;
							state_reg <= (state_reg == ST_PTR) ?
								ST_PTR_ACK : ST_WR_ACK;
						end else if (shift_reg[7:1] == DEV_ADDR) begin
							sda_oe    <= 1'b1;
							rw_reg    <= shift_reg[0];
							state_reg <= ST_ADDR_ACK;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						if (state_reg != ST_ADDR_ACK) begin
							state_reg <= ST_WR;
						end else if (rw_reg) begin
							shift_reg <= rd_val;
							sda_oe    <= ~rd_val[7];
							state_reg <= ST_RD;
						end else begin
							state_reg <= ST_PTR;
						end
					end
				end
				ST_RD: begin
					if (scl_rise) begin
						cnt_reg <= cnt_reg + 4'h1;
					end else if (byte_end) begin
						cnt_reg   <= 4'h0;
						sda_oe    <= 1'b0;
						state_reg <= ST_RD_ACK;
					end else if (scl_fall) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						sda_oe    <= ~shift_reg[6];
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						nack_reg <= sda_sync_reg[1];
					end else if (scl_fall) begin
						if (nack_reg) begin
							state_reg <= ST_IDLE;
						end else begin
							shift_reg <= rd_val;
							sda_oe    <= ~rd_val[7];
							state_reg <= ST_RD;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// Pointer walks on after every byte written or read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ptr_reg <= 8'h00;
		end else if (state_reg == ST_PTR && byte_end && !start_det &&
			!stop_det) begin
			ptr_reg <= shift_reg;
		end else if (wr_strobe || rd_byte_end) begin
			ptr_reg <= ptr_reg + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mask_reg <= FMAC_MASK_RST;
			chan_reg <= FMAC_CHAN_RST;
		end else if (reg_reset) begin
			// Register reset only; watchdog leaves the mask alone
			mask_reg <= FMAC_MASK_RST;
			chan_reg <= FMAC_CHAN_RST;
		end else if (wr_strobe) begin
			if (ptr_reg == FMAC_MASK_OFS) begin
				mask_reg <= shift_reg & FMAC_MASK_WMASK;
			end
			if (ptr_reg == FMAC_CHAN_OFS) begin
				chan_reg <= shift_reg & FMAC_CHAN_WMASK;
			end
		end
	end
	// Watchdog beats a host write to the enable, so a stuck host cannot
	// keep the converter running
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= FMAC_CTRL_RST;
		end else if (reg_reset) begin
			ctrl_reg <= FMAC_CTRL_RST;
		end else if (wdt_expire) begin
			ctrl_reg[FMAC_CTRL_EN_BIT] <= 1'b0;
		end else if (wr_strobe && ptr_reg == FMAC_CTRL_OFS) begin
			// Mode and speed held as written
			ctrl_reg <= shift_reg & FMAC_CTRL_WMASK;
		end else if (conv_done && ctrl_reg[FMAC_CTRL_RATE_BIT]) begin
			ctrl_reg[FMAC_CTRL_EN_BIT] <= 1'b0;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			conv_cfg    <= '0;
			channel_off <= FMAC_CHAN_RST;
		end else begin
			conv_cfg.enable   <= ctrl_reg[FMAC_CTRL_EN_BIT];
			conv_cfg.one_shot <= ctrl_reg[FMAC_CTRL_RATE_BIT];
			conv_cfg.speed    <= fmac_speed_type'(
				ctrl_reg[FMAC_CTRL_SPD_LSB +: 2]);
			channel_off       <= chan_reg;
		end
	end
	// Result taken only while on and channel not skipped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus_current_result_q <= FMAC_RES_RST;
		end else if (reg_reset) begin
			bus_current_result_q <= FMAC_RES_RST;
		end else if (result_valid && ctrl_reg[FMAC_CTRL_EN_BIT] &&
			!chan_reg[FMAC_CHAN_IBUS_BIT]) begin
			bus_current_result_q <= bus_current_result;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Fault edges; analog sources are synchronised first
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fault_s1_reg <= 8'h00;
			fault_s2_reg <= 8'h00;
			fault_d_reg  <= 8'h00;
			done_d_reg   <= 1'b0;
		end else begin
			fault_s1_reg <= faults & FMAC_MASK_WMASK;
			fault_s2_reg <= fault_s1_reg;
			fault_d_reg  <= fault_s2_reg;
			done_d_reg   <= conv_done;
		end
	end
	assign fault_rise = fault_s2_reg & ~fault_d_reg;
	// Done event counts in single-pass mode only
	assign done_event = conv_done & ~done_d_reg &
		ctrl_reg[FMAC_CTRL_RATE_BIT] & ~conv_done_irq_mask;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_pulse <= 1'b0;
		end else begin
			irq_pulse <= (|(fault_rise & ~mask_reg)) | done_event;
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_ovp_pulse:      assert property (fault_rise[7] && !mask_reg[7] |=>
		irq_pulse) else $error("input overvoltage edge lost");
	a_thermal_shutdown_irq_mask:     assert property (fault_rise == 8'h40 && mask_reg[6] &&
		!done_event |=> !irq_pulse) else $error("masked shutdown pulsed");
	a_battery_overvoltage_fault_pulse:   assert property (fault_rise[5] && !mask_reg[5] |=>
		irq_pulse) else $error("battery overvoltage edge lost");
	a_timer_mask:     assert property (fault_rise == 8'h10 && mask_reg[4] &&
		!done_event |=> !irq_pulse) else $error("masked timer pulsed");
	a_short_pulse:    assert property ($rose(fault_s2_reg[3]) &&
		!mask_reg[3] |=> irq_pulse) else $error("short edge lost");
	a_buck_pulse:     assert property (fault_rise[0] && !mask_reg[0] |=>
		irq_pulse) else $error("buck fault edge lost");
	a_mask_watchdog:  assert property (wdt_expire && !reg_reset &&
		!wr_strobe |=> $stable(mask_reg)) else $error("watchdog hit mask");
	a_enable_clear:   assert property (wdt_expire || reg_reset |=>
		!ctrl_reg[7] ##1 !conv_cfg.enable) else $error("enable not cleared");
	a_ctrl_reset:     assert property (reg_reset |=>
		ctrl_reg == 8'h30) else $error("control not back to 30h");
	a_ctrl_reserved:  assert property (ctrl_reg[3:0] == 4'h0)
		else $error("control reserved bits set");
	a_chan_reserved:  assert property (ptr_reg == 8'h16 |->
		rd_val[1]) else $error("channel bit 1 not one");
	a_result_hold:    assert property (!ctrl_reg[7] |=>
		$stable(bus_current_result_q) || $past(reg_reset))
		else $error("result moved while off");
	a_done_rate:      assert property (!ctrl_reg[6] |-> !done_event)
		else $error("done pulse in continuous mode");
	c_fault_irq:      cover property (fault_rise[7] ##1 irq_pulse);
	c_reg_write:      cover property (wr_strobe && ptr_reg == 8'h15);
	c_reg_read:       cover property (rd_byte_end ##[1:40] state_reg == ST_RD);
	c_one_shot_done:  cover property (done_event ##1 irq_pulse);

endmodule

// File: verification/fmac_host_model.sv
module fmac_host_model #(
	parameter logic [6:0] DEV = 7'h2A
)(
	input  wire logic  mclk,
	input  wire logic  sda_wire,
	output logic       scl,
	output logic       sda_low,
	output logic       rd_valid,
	output logic [7:0] rd_byte,
	output logic [7:0] nack_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// Phases kept above the five-cycle minimum of the slave
	localparam int PH = 6;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
		nack_cnt = 8'h00;
	end
	task automatic wt();
		repeat (PH) @(posedge mclk);
	endtask
	task automatic xbit(input logic b, output logic r);
		sda_low <= ~b;
		wt();
		scl <= 1'b1;
		wt();
		r = sda_wire;
		scl <= 1'b0;
		wt();
	endtask
	task automatic start();
		sda_low <= 1'b0;
		wt();
		scl <= 1'b1;
		wt();
		sda_low <= 1'b1;
		wt();
		scl <= 1'b0;
		wt();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		wt();
		scl <= 1'b1;
		wt();
		sda_low <= 1'b0;
		wt();
	endtask
	task automatic wbyte(input logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(v[i], r);
		xbit(1'b1, r);
		if (r) nack_cnt <= nack_cnt + 8'h01;
	endtask
	// Last byte is answered with a release, ending the read
	task automatic rbyte(input logic last);
		logic [7:0] v;
		logic       r;
		for (int i = 7; i >= 0; i--) xbit(1'b1, v[i]);
		xbit(last, r);
		rd_byte <= v;
		rd_valid <= 1'b1;
		@(posedge mclk);
		rd_valid <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] q[$]);
		start();
		wbyte({DEV, 1'b0});
		wbyte(ofs);
		foreach (q[i]) wbyte(q[i]);
		stop();
	endtask
	task automatic rd(input logic [7:0] ofs, input int n);
		start();
		wbyte({DEV, 1'b0});
		wbyte(ofs);
		start();
		wbyte({DEV, 1'b1});
		for (int i = 0; i < n; i++) rbyte(i == n - 1);
		stop();
	endtask
endmodule

// File: verification/fmac_regs_bench.sv
module fmac_regs_bench
	import fmac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst, reg_reset, wdt_expire, conv_done, done_mask;
	logic result_valid, sda_out, sda_oe, irq_pulse, scl, sda_low, rd_valid;
	fmac_fault_type    faults;
	fmac_conv_cfg_type conv_cfg;
	logic [7:0]        channel_off, rd_byte, nack_cnt, r0, r1, r2;
	logic [15:0]       cur, cur_q, held;
	logic [7:0]        exp_q[$];
	int                miscompares = 0, total_checks = 0;
	int                cycles = 0, irq_count = 0;
	int                fb[6] = '{7, 6, 5, 4, 3, 0};
	wire               sda_wire;
	// Open-drain line with pull-up
	assign sda_wire = ~(sda_oe | sda_low);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	fmac_regs u_fmac_regs (.mclk(mclk), .rst(rst), .scl_in(scl),
		.sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
		.reg_reset(reg_reset), .wdt_expire(wdt_expire), .faults(faults),
		.conv_done(conv_done), .conv_done_irq_mask(done_mask),
		.result_valid(result_valid), .bus_current_result(cur),
		.irq_pulse(irq_pulse), .conv_cfg(conv_cfg),
		.channel_off(channel_off), .bus_current_result_q(cur_q));
	fmac_host_model u_fmac_host_model (.mclk(mclk), .sda_wire(sda_wire),
		.scl(scl), .sda_low(sda_low), .rd_valid(rd_valid),
		.rd_byte(rd_byte), .nack_cnt(nack_cnt));
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (irq_pulse === 1'b1) irq_count++;
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("Error at %0t: unexpected read", $time);
			end else
				check(rd_byte, exp_q.pop_front());
		end
		if (cycles == 60000) begin
			miscompares++;
			$display("Error at %0t: run hung", $time);
			summarize();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic rdx(input logic [7:0] ofs, input logic [7:0] e[$]);
		foreach (e[i]) exp_q.push_back(e[i]);
		u_fmac_host_model.rd(ofs, e.size());
	endtask
	task automatic fault(input int b, input int n);
		int base;
		base = irq_count;
		faults[b] <= 1'b1;
		tick(8);
		faults <= '0;
		tick(6);
		check(16'(irq_count - base), 16'(n));
	endtask
	task automatic done_pulse(input int n);
		int base;
		base = irq_count;
		conv_done <= 1'b1;
		tick(1);
		conv_done <= 1'b0;
		tick(4);
		check(16'(irq_count - base), 16'(n));
	endtask
	task automatic feed(input logic [15:0] v);
		cur <= v;
		result_valid <= 1'b1;
		tick(1);
		result_valid <= 1'b0;
		tick(2);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		reg_reset = 1'b0;
		wdt_expire = 1'b0;
		faults = '0;
		conv_done = 1'b0;
		done_mask = 1'b0;
		result_valid = 1'b0;
		cur = 16'h0000;
		void'($urandom(32'hA8C6));
		tick(10);
		rst <= 1'b0;
		tick(4);
		// Reset values, pointer runs on into unmapped space
		rdx(FMAC_MASK_OFS, '{8'h00, 8'h30, 8'h02, 8'h00, 8'h00});
		r0 = 8'($urandom);
		r1 = 8'($urandom);
		r2 = 8'($urandom);
		u_fmac_host_model.wr(FMAC_MASK_OFS, '{r0, r1, r2});
		rdx(FMAC_MASK_OFS, '{r0 & 8'hF9, r1 & 8'hF0, r2 & 8'hFD | 8'h02});
		check(channel_off, r2 & 8'hFD);
		check(conv_cfg, r1[7:4]);
		// Watchdog drops only the enable
		u_fmac_host_model.wr(FMAC_CTRL_OFS, '{8'hC0});
		wdt_expire <= 1'b1;
		tick(1);
		wdt_expire <= 1'b0;
		tick(2);
		rdx(FMAC_MASK_OFS, '{r0 & 8'hF9, 8'h40});
		check(conv_cfg, 4'h4);
		// Capture only while enabled and channel on
		u_fmac_host_model.wr(FMAC_CTRL_OFS, '{8'h80, 8'h00});
		held = 16'($urandom);
		feed(held);
		check(cur_q, held);
		rdx(FMAC_RES_HI_OFS, '{held[15:8]});
		u_fmac_host_model.wr(FMAC_CHAN_OFS, '{8'h80});
		feed(~held);
		check(cur_q, held);
		u_fmac_host_model.wr(FMAC_CTRL_OFS, '{8'h00, 8'h00});
		feed(~held);
		check(cur_q, held);
		// Done interrupt only in single pass, unmasked
		u_fmac_host_model.wr(FMAC_CTRL_OFS, '{8'hC0});
		done_pulse(1);
		u_fmac_host_model.wr(FMAC_CTRL_OFS, '{8'hC0});
		done_mask <= 1'b1;
		done_pulse(0);
		done_mask <= 1'b0;
		u_fmac_host_model.wr(FMAC_CTRL_OFS, '{8'h80});
		done_pulse(0);
		// Each fault unmasked, then masked by its own bit
		u_fmac_host_model.wr(FMAC_MASK_OFS, '{8'h00});
		foreach (fb[i]) fault(fb[i], 1);
		fault(2, 0);
		foreach (fb[i]) begin
			u_fmac_host_model.wr(FMAC_MASK_OFS, '{8'h01 << fb[i]});
			fault(fb[i], 0);
		end
		// Foreign address is left unanswered
		u_fmac_host_model.start();
		u_fmac_host_model.wbyte({7'h2B, 1'b0});
		u_fmac_host_model.stop();
		check(nack_cnt, 8'h01);
		reg_reset <= 1'b1;
		tick(1);
		reg_reset <= 1'b0;
		tick(2);
		rdx(FMAC_MASK_OFS, '{8'h00, 8'h30, 8'h02, 8'h00});
		tick(4);
		check(16'(exp_q.size()), 16'h0000);
		// Open drain: the data output never carries a high level
		check(16'(sda_out), 16'h0000);
		summarize();
	end
endmodule
